// *** hw/fcr_map.vh ***
// fcr_map.vh: register offsets, field positions, reset values, tags and limits
// for the queue compression runtime control block.
// assumes a 32-bit Avalon-MM slave with byte addressing.
`ifndef FCR_MAP_VH
`define FCR_MAP_VH

// ===========================================================================
// register offsets (byte addresses)
`define FCR_OFS_CTRL        4'h0
`define FCR_OFS_STATUS      4'h4

// ===========================================================================
// control register fields (queue_control_two)
`define FCR_CTRL_EN_BIT     0
`define FCR_CTRL_PER_LO     1
`define FCR_CTRL_PER_HI     2
`define FCR_CTRL_REINIT_BIT 3
`define FCR_CTRL_RESET_EN   1'b0
`define FCR_CTRL_RESET_PER  2'b00

// ===========================================================================
// status register fields
`define FCR_ST_STARTED_BIT  0
`define FCR_ST_PEND_LO      1
`define FCR_ST_PEND_HI      2
`define FCR_ST_FLUSH_BIT    3
`define FCR_ST_BUSY_BIT     4
`define FCR_ST_CNT_LO       8
`define FCR_ST_CNT_HI       13

// ===========================================================================
// word tags
`define FCR_TAG_NC          5'h02
`define FCR_TAG_NC_LAG1     5'h07
`define FCR_TAG_NC_LAG2     5'h06
`define FCR_TAG_DOUBLE      5'h08
`define FCR_TAG_TRIPLE      5'h09
`define FCR_TAG_TIMESTAMP   5'h04
`define FCR_TAG_CFG_CHANGE  5'h0E

// ===========================================================================
// forced uncompressed periods, in batch events
`define FCR_PER_OFF         2'b00
`define FCR_PER_8           2'b01
`define FCR_PER_16          2'b10
`define FCR_PER_32          2'b11
`define FCR_WINDOW_SLACK    6'h03

`endif

// *** hw/fcr_compress_ctrl.v ***
// fcr_compress_ctrl.v: runtime control of a sensor queue compression stage.
// assumes batch events, samples, config-change pulses and timestamp come from
// logic on ref_clk_i; batch events are at least 6 cycles apart.
//
// Overview of operation
// R1: compressed samples wait two batch periods before writing
// R2: host disables compression when low latency needed
// R3: enable toggle accepted; handled as configuration change
// R4: marker word at first batch event after change
// R5: pending window flushed uncompressed, tagged by lag
// R6: flushed words oldest first after timestamp word
// R7: config change with compression on: flush then resume
// R8: host splits old and new configuration at marker
// R9: period field: off, 8, 16 or 32 events
// R10: uncompressed reference written within configured sample count
// R11: host waits for fresh reference after overrun
// R12: host reinitialises compressor after bypass mode
// R13: double word eight-bit diffs, triple five-bit diffs
// R14: host adds each difference to previous decoded sample
// R15: first event current uncompressed, then packed or lag-two
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fcr_map.vh"

module fcr_compress_ctrl (
   input  wire        ref_clk_i,
   input  wire        reset_i,
   input  wire [3:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   output reg  [31:0] avs_readdata_o,
   output reg         avs_waitrequest_o,
   input  wire        batch_event_i,
   input  wire        config_change_i,
   input  wire [15:0] sample_x_i,
   input  wire [15:0] sample_y_i,
   input  wire [15:0] sample_z_i,
   input  wire [31:0] timestamp_i,
   output reg         word_valid_o,
   output reg  [4:0]  word_tag_o,
   output reg  [47:0] word_data_o
);

   // ========================================================================
   // sequencer states
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_MARK = 3'd1;
   localparam [2:0] ST_TS   = 3'd2;
   localparam [2:0] ST_LAG2 = 3'd3;
   localparam [2:0] ST_LAG1 = 3'd4;
   localparam [2:0] ST_CUR  = 3'd5;

   // ========================================================================
   // helpers
   function [47:0] lane_sub;
      input [47:0] a;
      input [47:0] b;
      begin
         lane_sub = {a[47:32] - b[47:32], a[31:16] - b[31:16], a[15:0] - b[15:0]};
      end
   endfunction

   function fit5;
      input [47:0] d;
      integer k;
      begin
         fit5 = 1'b1;
         for (k = 0; k < 3; k = k + 1) begin
            if (!((d[16*k+4 +: 12] == 12'h000) || (d[16*k+4 +: 12] == 12'hfff)))
               fit5 = 1'b0;
         end
      end
   endfunction

   function fit8;
      input [47:0] d;
      integer k;
      begin
         fit8 = 1'b1;
         for (k = 0; k < 3; k = k + 1) begin
            if (!((d[16*k+7 +: 9] == 9'h000) || (d[16*k+7 +: 9] == 9'h1ff)))
               fit8 = 1'b0;
         end
      end
   endfunction

   // one sample's three diffs in one 16-bit axis word, bit 15 zero
   function [15:0] pack5;
      input [47:0] d;
      begin
         pack5 = {1'b0, d[36:32], d[20:16], d[4:0]};
      end
   endfunction

   function [23:0] pack8;
      input [47:0] d;
      begin
         pack8 = {d[39:32], d[23:16], d[7:0]};
      end
   endfunction

   function [5:0] period_limit;
      input [1:0] sel;
      begin
         case (sel)
            `FCR_PER_8:  period_limit = 6'd8;
            `FCR_PER_16: period_limit = 6'd16;
            `FCR_PER_32: period_limit = 6'd32;
            default:     period_limit = 6'd0;
         endcase
      end
   endfunction

   // ========================================================================
   // state
   reg        comp_en;
   reg [1:0]  period_sel;
   reg        flush_req;
   reg        started;
   reg [1:0]  pend;
   reg [47:0] lag2;
   reg [47:0] lag1;
   reg [47:0] prev;
   reg [47:0] cur;
   reg [31:0] ts_hold;
   reg [5:0]  nc_cnt;
   reg [2:0]  state;

   wire [47:0] sample_now = {sample_z_i, sample_y_i, sample_x_i};
   wire [47:0] d2         = lane_sub(lag2, prev);
   wire [47:0] d1         = lane_sub(lag1, lag2);
   wire [47:0] d0         = lane_sub(sample_now, lag1);
   wire [5:0]  plim       = period_limit(period_sel);
   // a decision can be up to three events away, so force early by that slack;
   // summed on seven bits so a saturated count cannot wrap below the limit
   wire        force_nc   = (plim != 6'd0) && ({1'b0, nc_cnt} + {1'b0, `FCR_WINDOW_SLACK} >= {1'b0, plim});  // [R10]

   wire        bus_take   = avs_write_i && !avs_waitrequest_o;
   wire        ctrl_wr    = bus_take && (avs_address_i == `FCR_OFS_CTRL) && avs_byteenable_i[0];
   wire        toggle     = ctrl_wr && (avs_writedata_i[`FCR_CTRL_EN_BIT] != comp_en);
   wire        reinit     = ctrl_wr && avs_writedata_i[`FCR_CTRL_REINIT_BIT];
   wire        take_flush = batch_event_i && (state == ST_IDLE) && flush_req;

   // ========================================================================
   // avalon slave: one wait cycle, then answer
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else if (!avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b1;
      end else if (avs_read_i || avs_write_i) begin
         avs_waitrequest_o <= 1'b0;
         avs_readdata_o    <= 32'h0000_0000;
         if (avs_read_i && avs_address_i == `FCR_OFS_CTRL) begin
            avs_readdata_o[`FCR_CTRL_EN_BIT]                   <= comp_en;
            avs_readdata_o[`FCR_CTRL_PER_HI:`FCR_CTRL_PER_LO] <= period_sel;
         end else if (avs_read_i && avs_address_i == `FCR_OFS_STATUS) begin
            avs_readdata_o[`FCR_ST_STARTED_BIT]             <= started;
            avs_readdata_o[`FCR_ST_PEND_HI:`FCR_ST_PEND_LO] <= pend;
            avs_readdata_o[`FCR_ST_FLUSH_BIT]               <= flush_req;
            avs_readdata_o[`FCR_ST_BUSY_BIT]                <= (state != ST_IDLE);
            avs_readdata_o[`FCR_ST_CNT_HI:`FCR_ST_CNT_LO]   <= nc_cnt;
         end
      end
   end

   // ========================================================================
   // control register
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         comp_en    <= `FCR_CTRL_RESET_EN;
         period_sel <= `FCR_CTRL_RESET_PER;
      end else if (ctrl_wr) begin
         comp_en    <= avs_writedata_i[`FCR_CTRL_EN_BIT];                    // [R3]
         period_sel <= avs_writedata_i[`FCR_CTRL_PER_HI:`FCR_CTRL_PER_LO];   // [R9]
      end
   end

   // a new change in the cycle the old one is taken keeps the request alive
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i)
         flush_req <= 1'b0;
      else
         flush_req <= config_change_i || toggle || (flush_req && !take_flush);  // [R3] [R7]
   end

   // ========================================================================
   // compression window and output sequencer
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         started      <= 1'b0;
         pend         <= 2'd0;
         lag2         <= 48'h0000_0000_0000;
         lag1         <= 48'h0000_0000_0000;
         prev         <= 48'h0000_0000_0000;
         cur          <= 48'h0000_0000_0000;
         ts_hold      <= 32'h0000_0000;
         nc_cnt       <= 6'd0;
         state        <= ST_IDLE;
         word_valid_o <= 1'b0;
         word_tag_o   <= 5'h00;
         word_data_o  <= 48'h0000_0000_0000;
      end else begin
         word_valid_o <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (reinit) begin
                  started <= 1'b0;
                  pend    <= 2'd0;
                  nc_cnt  <= 6'd0;
               end else if (take_flush) begin
                  cur     <= sample_now;
                  ts_hold <= timestamp_i;
                  state   <= ST_MARK;                                        // [R4]
               end else if (batch_event_i) begin
                  if (nc_cnt != 6'd63)
                     nc_cnt <= nc_cnt + 6'd1;
                  if (!comp_en || !started) begin
                     word_valid_o <= 1'b1;                                   // [R3] [R15]
                     word_tag_o   <= `FCR_TAG_NC;
                     word_data_o  <= sample_now;
                     prev         <= sample_now;
                     started      <= comp_en;
                     pend         <= 2'd0;
                     nc_cnt       <= 6'd0;
                  end else if (pend == 2'd0) begin
                     lag2 <= sample_now;                                     // [R1]
                     pend <= 2'd1;
                  end else if (pend == 2'd1) begin
                     lag1 <= sample_now;                                     // [R1]
                     pend <= 2'd2;
                  end else if (!force_nc && fit5(d2) && fit5(d1) && fit5(d0)) begin
                     word_valid_o <= 1'b1;                                   // [R13] [R15]
                     word_tag_o   <= `FCR_TAG_TRIPLE;
                     word_data_o  <= {pack5(d0), pack5(d1), pack5(d2)};
                     prev         <= sample_now;
                     pend         <= 2'd0;
                  end else if (!force_nc && fit8(d2) && fit8(d1)) begin
                     word_valid_o <= 1'b1;                                   // [R13] [R15]
                     word_tag_o   <= `FCR_TAG_DOUBLE;
                     word_data_o  <= {pack8(d1), pack8(d2)};
                     prev         <= lag1;
                     lag2         <= sample_now;
                     pend         <= 2'd1;
                  end else begin
                     word_valid_o <= 1'b1;                                   // [R10] [R15]
                     word_tag_o   <= `FCR_TAG_NC_LAG2;
                     word_data_o  <= lag2;
                     prev         <= lag2;
                     lag2         <= lag1;
                     lag1         <= sample_now;
                     nc_cnt       <= 6'd0;
                  end
               end
            end
            ST_MARK: begin
               word_valid_o <= 1'b1;                                         // [R4]
               word_tag_o   <= `FCR_TAG_CFG_CHANGE;
               word_data_o  <= 48'h0000_0000_0000;
               state        <= ST_TS;
            end
            ST_TS: begin
               word_valid_o <= 1'b1;                                         // [R5]
               word_tag_o   <= `FCR_TAG_TIMESTAMP;
               word_data_o  <= {16'h0000, ts_hold};
               state        <= (pend == 2'd2) ? ST_LAG2 : ((pend == 2'd1) ? ST_LAG1 : ST_CUR);
            end
            ST_LAG2: begin
               word_valid_o <= 1'b1;                                         // [R5] [R6]
               word_tag_o   <= `FCR_TAG_NC_LAG2;
               word_data_o  <= lag2;
               state        <= ST_LAG1;
            end
            ST_LAG1: begin
               word_valid_o <= 1'b1;                                         // [R5] [R6]
               word_tag_o   <= `FCR_TAG_NC_LAG1;
               word_data_o  <= (pend == 2'd2) ? lag1 : lag2;
               state        <= ST_CUR;
            end
            ST_CUR: begin
               word_valid_o <= 1'b1;                                         // [R5] [R6]
               word_tag_o   <= `FCR_TAG_NC;
               word_data_o  <= cur;
               prev         <= cur;
               pend         <= 2'd0;
               nc_cnt       <= 6'd0;
               started      <= comp_en;                                      // [R7]
               state        <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // fcr_compress_ctrl
`default_nettype wire

// *** tb/fcr_host_model.sv ***
// host-side model: decodes the tagged queue word stream on the x axis
// assumes one word per cycle on ref_clk_i, tags as in fcr_map.vh
`timescale 1ns/100ps
`default_nettype none
`include "fcr_map.vh"
module fcr_host_model (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic        word_valid_i,
   input  wire logic [4:0]  word_tag_i,
   input  wire logic [47:0] word_data_i,
   output var  logic [15:0] decoded_x_o,
   output var  logic [7:0]  epoch_o
);
   // ======================================
   // decoder
   function automatic logic [15:0] s5(input logic [4:0] d);
      return {{11{d[4]}}, d};
   endfunction
   function automatic logic [15:0] s8(input logic [7:0] d);
      return {{8{d[7]}}, d};
   endfunction
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         decoded_x_o <= 16'h0000;
         epoch_o     <= 8'h00;
      end else if (word_valid_i) begin
         case (word_tag_i)
            `FCR_TAG_CFG_CHANGE: epoch_o <= epoch_o + 8'h01;
            `FCR_TAG_NC, `FCR_TAG_NC_LAG1, `FCR_TAG_NC_LAG2: decoded_x_o <= word_data_i[15:0];
            `FCR_TAG_TRIPLE: decoded_x_o <= decoded_x_o + s5(word_data_i[4:0]) + s5(word_data_i[20:16])
               + s5(word_data_i[36:32]);
            `FCR_TAG_DOUBLE: decoded_x_o <= decoded_x_o + s8(word_data_i[7:0]) + s8(word_data_i[31:24]);
            default: ;
         endcase
      end
   end
endmodule // fcr_host_model
`default_nettype wire

// *** tb/fcr_compress_ctrl_asserts.sv ***
// checker for the compression control block, bound to its ports
// assumes one clock, reset_i asynchronous and active high
`timescale 1ns/100ps
`default_nettype none
`include "fcr_map.vh"
module fcr_compress_ctrl_asserts (
   input wire logic        ref_clk_i,
   input wire logic        reset_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic        avs_waitrequest_o,
   input wire logic        batch_event_i,
   input wire logic [15:0] sample_x_i,
   input wire logic [15:0] sample_y_i,
   input wire logic [15:0] sample_z_i,
   input wire logic [31:0] timestamp_i,
   input wire logic        word_valid_o,
   input wire logic [4:0]  word_tag_o,
   input wire logic [47:0] word_data_o
);
   // ======================================
   // properties
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   logic req;
   assign req = avs_read_i | avs_write_i;
   property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low for two cycles");
   property p_wait_answer; $rose(req) |=> !avs_waitrequest_o; endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("bus access not answered");
   property p_word_cause; $rose(word_valid_o) && word_tag_o != `FCR_TAG_CFG_CHANGE
      |-> $past(batch_event_i); endproperty
   a_word_cause: assert property (p_word_cause) else $error("word without batch event");
   property p_marker_cause; word_valid_o && word_tag_o == `FCR_TAG_CFG_CHANGE
      |-> $past(batch_event_i, 2); endproperty
   a_marker_cause: assert property (p_marker_cause) else $error("marker not tied to batch event");
   property p_marker_ts;
      word_valid_o && word_tag_o == `FCR_TAG_CFG_CHANGE |-> word_data_o == 48'h0000_0000_0000 ##1
      word_valid_o && word_tag_o == `FCR_TAG_TIMESTAMP && word_data_o == {16'h0000, $past(timestamp_i, 3)};
   endproperty
   a_marker_ts: assert property (p_marker_ts) else $error("marker not followed by timestamp");
   property p_ts_next;
      word_valid_o && word_tag_o == `FCR_TAG_TIMESTAMP |=> word_valid_o && (word_tag_o == `FCR_TAG_NC_LAG2
      || word_tag_o == `FCR_TAG_NC_LAG1 || word_tag_o == `FCR_TAG_NC);
   endproperty
   a_ts_next: assert property (p_ts_next) else $error("flush word missing after timestamp");
   property p_flush_order;
      word_valid_o && word_tag_o == `FCR_TAG_TIMESTAMP ##1 word_valid_o && word_tag_o == `FCR_TAG_NC_LAG2
      |=> word_valid_o && word_tag_o == `FCR_TAG_NC_LAG1 ##1 word_valid_o && word_tag_o == `FCR_TAG_NC;
   endproperty
   a_flush_order: assert property (p_flush_order) else $error("flush words out of age order");
   property p_lag1_nc; word_valid_o && word_tag_o == `FCR_TAG_NC_LAG1 |=> word_valid_o
      && word_tag_o == `FCR_TAG_NC; endproperty
   a_lag1_nc: assert property (p_lag1_nc) else $error("lag-one not followed by current");
   property p_nc_data; word_valid_o && word_tag_o == `FCR_TAG_NC && $past(batch_event_i)
      |-> word_data_o == $past({sample_z_i, sample_y_i, sample_x_i}); endproperty
   a_nc_data: assert property (p_nc_data) else $error("current word data wrong");
   property p_triple_pad; word_valid_o && word_tag_o == `FCR_TAG_TRIPLE
      |-> !word_data_o[15] && !word_data_o[31] && !word_data_o[47]; endproperty
   a_triple_pad: assert property (p_triple_pad) else $error("triple word top bits set");
   c_marker: cover property (word_valid_o && word_tag_o == `FCR_TAG_CFG_CHANGE);
   c_triple: cover property (word_valid_o && word_tag_o == `FCR_TAG_TRIPLE);
   c_lag2: cover property (word_valid_o && word_tag_o == `FCR_TAG_NC_LAG2);
   c_double: cover property (word_valid_o && word_tag_o == `FCR_TAG_DOUBLE);
endmodule // fcr_compress_ctrl_asserts
bind fcr_compress_ctrl fcr_compress_ctrl_asserts i_chk (.ref_clk_i, .reset_i, .avs_read_i, .avs_write_i,
   .avs_waitrequest_o, .batch_event_i, .sample_x_i, .sample_y_i, .sample_z_i, .timestamp_i, .word_valid_o,
   .word_tag_o, .word_data_o);
`default_nettype wire

// *** tb/fcr_compress_ctrl_test.sv ***
// self-checking bench for the compression control block
// assumes the host model and the bound checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "fcr_map.vh"
module fcr_compress_ctrl_test;
   logic        clk = 1'b0, rst = 1'b1, rd_s = 1'b0, wr_s = 1'b0, batch = 1'b0, cfg = 1'b0, watch = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000, ts = 32'h0000_0000, nts = 32'h0000_0000, rdata, r;
   logic [15:0] sx = 16'h0000, sy = 16'h0000, sz = 16'h0000, dx;
   logic [15:0] x0 = 16'h0123, rx;
   logic [7:0]  epoch;
   logic        wreq, vld;
   logic [4:0]  tag;
   logic [47:0] data;
   logic [52:0] q[$];
   int          bad_count = 0, n_tests = 0, gap = 0, gap_max = 0;
   fcr_compress_ctrl i_dut (.ref_clk_i(clk), .reset_i(rst), .avs_address_i(addr), .avs_read_i(rd_s),
      .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .batch_event_i(batch), .config_change_i(cfg), .sample_x_i(sx),
      .sample_y_i(sy), .sample_z_i(sz), .timestamp_i(ts), .word_valid_o(vld), .word_tag_o(tag),
      .word_data_o(data));
   fcr_host_model i_host (.ref_clk_i(clk), .reset_i(rst), .word_valid_i(vld), .word_tag_i(tag),
      .word_data_i(data), .decoded_x_o(dx), .epoch_o(epoch));
   // ======================================
   // helpers
   initial forever #10 clk = ~clk;
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [52:0] got, input logic [52:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [52:0] note(input logic [4:0] t, input logic [15:0] x);
      return {t, x + 16'h0100, ~x, x};
   endfunction
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] v);
      @(posedge clk);
      rd_s <= !we; wr_s <= we; addr <= a; wdata <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      v = rdata;
      rd_s <= 1'b0; wr_s <= 1'b0;
   endtask
   task automatic ev(input logic [15:0] x);
      @(posedge clk);
      batch <= 1'b1; sx <= x; sy <= ~x; sz <= x + 16'h0100; ts <= nts;
      @(posedge clk);
      batch <= 1'b0;
      nts = $urandom;
      repeat (6) @(posedge clk);
   endtask
   task automatic flush_ev(input int np, input logic [15:0] x);
      q.push_back({`FCR_TAG_CFG_CHANGE, 48'h0000_0000_0000});
      q.push_back({`FCR_TAG_TIMESTAMP, 16'h0000, nts});
      if (np == 2) q.push_back(note(`FCR_TAG_NC_LAG2, x - 16'h0002));
      if (np > 0) q.push_back(note(`FCR_TAG_NC_LAG1, x - 16'h0001));
      q.push_back(note(`FCR_TAG_NC, x));
      ev(x);
   endtask
   // ======================================
   // result watcher: each word takes the oldest note
   always @(posedge clk) begin
      if (vld === 1'b1 && (tag == `FCR_TAG_NC || tag == `FCR_TAG_NC_LAG1 || tag == `FCR_TAG_NC_LAG2)) gap = 0;
      if (batch === 1'b1) begin
         gap++;
         if (gap > gap_max) gap_max = gap;
      end
      if (vld === 1'b1 && watch) chk({tag, data}, q.size() > 0 ? q.pop_front() : 53'h1F_0000_0000_0000);
   end
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      finish_test();
   end
   // ======================================
   // scenarios
   initial begin
      r = $urandom(53417);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 4'h0, 32'h0000_0000, r); chk(53'(r), 53'h0);
      bus(1'b1, 4'h8, 32'hFFFF_FFFF, r); bus(1'b0, 4'h8, 32'h0000_0000, r); chk(53'(r), 53'h0);
      watch = 1'b1;
      repeat (3) begin
         rx = 16'($urandom);
         q.push_back(note(`FCR_TAG_NC, rx));
         ev(rx);
      end
      bus(1'b1, 4'h0, 32'h0000_0001, r); bus(1'b0, 4'h0, 32'h0000_0000, r); chk(53'(r), 53'h1);
      flush_ev(0, x0);
      ev(x0); ev(x0);
      bus(1'b0, 4'h4, 32'h0000_0000, r); chk(53'(r), 53'h205);
      q.push_back({`FCR_TAG_TRIPLE, 48'h0000_0000_0000});
      ev(x0);
      ev(x0 + 16'h0001); ev(x0 + 16'h0002);
      @(posedge clk) cfg <= 1'b1;
      @(posedge clk) cfg <= 1'b0;
      flush_ev(2, x0 + 16'h0003);
      ev(x0 + 16'h0003); ev(x0 + 16'h0003);
      q.push_back({`FCR_TAG_TRIPLE, 48'h0000_0000_0000});
      ev(x0 + 16'h0003);
      chk(53'(dx), 53'(x0 + 16'h0003)); chk(53'(epoch), 53'h2);
      q.push_back({`FCR_TAG_DOUBLE, 48'h20E0_2020_E020});
      ev(x0 + 16'h0023); ev(x0 + 16'h0043); ev(x0 + 16'h0004);
      chk(53'(dx), 53'(x0 + 16'h0043));
      bus(1'b1, 4'h0, 32'h0000_0000, r);
      flush_ev(1, x0 + 16'h0005);
      q.push_back(note(`FCR_TAG_NC, x0 + 16'h0006));
      ev(x0 + 16'h0006);
      chk(53'(epoch), 53'h3);
      bus(1'b1, 4'h0, 32'h0000_0008, r); bus(1'b0, 4'h0, 32'h0000_0000, r); chk(53'(r), 53'h0);
      chk(53'(q.size()), 53'h0);
      watch = 1'b0;
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, 4'h0, {28'h000_0000, 1'b0, 2'(p), 1'b1}, r);
         repeat (4) ev(x0);
         gap_max = 0;
         repeat (40) ev(x0);
         if (p == 0) chk(53'(gap_max > 32), 53'h1);
         else chk(53'(gap_max <= (4 << p)), 53'h1);
      end
      finish_test();
   end
endmodule // fcr_compress_ctrl_test
`default_nettype wire
